/* File: uart_serial_defines.vh */
// constants for the serial port control block
// assumes an 8-bit special-function register port at the documented addresses
`ifndef UART_SERIAL_DEFINES_VH
`define UART_SERIAL_DEFINES_VH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define SPC_ADDR        8'h98
`define SDB_ADDR        8'h99

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SPC_MODE_BIT    7
`define SPC_UNUSED_BIT  6
`define SPC_MCE_BIT     5
`define SPC_REN_BIT     4
`define SPC_TB8_BIT     3
`define SPC_RB8_BIT     2
`define SPC_TI_BIT      1
`define SPC_RI_BIT      0
`define SPC_RESET       8'h40

// ----------------------------------------------------------------------------
// framing and timing
// ----------------------------------------------------------------------------
`define OVF_PER_BIT     2
`define RX_SAMPLE_OVF   1
`define FRAME8_BITS     4'd10
`define FRAME9_BITS     4'd11

`endif

/* File: baud_timer.v */
// 8-bit auto-reload timer producing a one-cycle overflow pulse
// assumes tick is a one-cycle count enable on clk
`timescale 1ns/1ps
`default_nettype none

module baud_timer #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             tick,
    input  wire             restart,
    input  wire [WIDTH-1:0] reloadValue,
    output reg              overflow
);

    reg [WIDTH-1:0] count_r;

    always @(posedge clk) begin
        if (reset) begin
            count_r  <= {WIDTH{1'b0}};
            overflow <= 1'b0;
        end else if (restart) begin
            count_r  <= reloadValue;
            overflow <= 1'b0;
        end else if (tick) begin
            overflow <= &count_r;
            count_r  <= (&count_r) ? reloadValue : count_r + 1'b1;
        end else begin
            overflow <= 1'b0;
        end
    end

endmodule // baud_timer

`default_nettype wire

/* File: uart_serial_port_control.v */
// serial port control: framing, receive gating, flags and data buffer
// assumes a synchronous 8-bit register port, timer tick from the system timer
`timescale 1ns/1ps
`default_nettype none

`include "uart_serial_defines.vh"

// Contract
// R1 - control bit 7 selects 8-bit framing at 0, 9-bit framing at 1
// R2 - control bit 6 reads one, writes ignored
// R3 - 8-bit mode: with address match enabled, receive needs stop bit one
// R4 - 9-bit mode: with address match enabled, receive needs ninth bit one
// R5 - no frame is received while receive gate is zero; code gates only the start edge, so a frame already begun is still received
// R6 - 9-bit mode sends tx ninth bit as ninth bit; ignored in 8-bit
// R7 - accepted frame loads rx ninth bit with stop bit or ninth bit
// R8 - tx done sets after 8th data bit or at start of stop bit
// R9 - rx done sets when stop bit of accepted byte is sampled
// R10 - hardware never clears done flags; software writes zero
// R11 - either done flag raises interrupt while interrupt is enabled
// R12 - bit rate is timer overflow halved; receive timer reloads on start edge
// R13 - frame is start, eight data bits lsb first, stop
// R14 - data buffer write starts transmit; read returns received byte
// R15 - buffer loads only if rx done clear and address check passes
// R16 - transmit line idles high
module uart_serial_port_control #(
    parameter TIMER_WIDTH = 8
) (
    input  wire                   clk,
    input  wire                   reset,
    input  wire                   timerTick,
    input  wire [TIMER_WIDTH-1:0] baudTimerReload,
    input  wire                   intEnable,
    input  wire [7:0]             regAddr,
    input  wire                   regWrite,
    input  wire [7:0]             regWdata,
    input  wire                   regRead,
    output reg  [7:0]             regRdata,
    input  wire                   rxPin,
    output reg                    txPin,
    output wire                   irq
);

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    reg       frameWidthSelect_r;
    reg       addressMatchEnable_r;
    reg       receiveGate_r;
    reg       txNinthBit_r;
    reg       rxNinthBit_r;
    reg       txDoneFlag_r;
    reg       rxDoneFlag_r;
    reg [7:0] serialDataBuffer_r;

    wire ctlWr = regWrite && (regAddr == `SPC_ADDR);
    wire bufWr = regWrite && (regAddr == `SDB_ADDR);

    wire txDoneSet;
    wire rxAccept;
    wire rxNinthValue;
    wire [7:0] rxByte;

    wire [7:0] ctlValue = {frameWidthSelect_r, 1'b1, addressMatchEnable_r, // see R2
                           receiveGate_r, txNinthBit_r, rxNinthBit_r,
                           txDoneFlag_r, rxDoneFlag_r};

    always @(posedge clk) begin
        if (reset) begin
            frameWidthSelect_r   <= 1'b0;
            addressMatchEnable_r <= 1'b0;
            receiveGate_r        <= 1'b0;
            txNinthBit_r         <= 1'b0;
            rxNinthBit_r         <= 1'b0;
            txDoneFlag_r         <= 1'b0;
            rxDoneFlag_r         <= 1'b0;
            serialDataBuffer_r   <= 8'h00;
        end else begin
            if (ctlWr) begin
                frameWidthSelect_r   <= regWdata[`SPC_MODE_BIT]; // see R1
                addressMatchEnable_r <= regWdata[`SPC_MCE_BIT];
                receiveGate_r        <= regWdata[`SPC_REN_BIT];
                txNinthBit_r         <= regWdata[`SPC_TB8_BIT];
                rxNinthBit_r         <= regWdata[`SPC_RB8_BIT];
                txDoneFlag_r         <= regWdata[`SPC_TI_BIT]; // see R10
                rxDoneFlag_r         <= regWdata[`SPC_RI_BIT]; // see R10
            end
            // set wins over a software clear in the same cycle
            if (txDoneSet)
                txDoneFlag_r <= 1'b1; // see R8
            if (rxAccept) begin
                rxDoneFlag_r       <= 1'b1;         // see R9
                rxNinthBit_r       <= rxNinthValue; // see R7
                serialDataBuffer_r <= rxByte;       // see R15
            end
        end
    end

    always @(posedge clk) begin
        if (reset)
            regRdata <= 8'h00;
        else if (regRead && regAddr == `SPC_ADDR)
            regRdata <= ctlValue;
        else if (regRead && regAddr == `SDB_ADDR)
            regRdata <= serialDataBuffer_r; // see R14
        else if (regRead)
            regRdata <= 8'h00;
    end

    assign irq = intEnable && (txDoneFlag_r || rxDoneFlag_r); // see R11

    // ------------------------------------------------------------------------
    // bit timers
    // ------------------------------------------------------------------------
    // receive copy of the timer restarts on a start edge, independent of tx
    wire txOvf;
    wire rxOvf;
    reg  rxPrev_r;
    reg  rxActive_r;
    wire startEdge = receiveGate_r && !rxActive_r && rxPrev_r && !rxPin; // see R5

    baud_timer #(.WIDTH(TIMER_WIDTH)) txTimer (
        .clk         (clk),
        .reset       (reset),
        .tick        (timerTick),
        .restart     (1'b0),
        .reloadValue (baudTimerReload),
        .overflow    (txOvf)
    );

    baud_timer #(.WIDTH(TIMER_WIDTH)) rxTimer (
        .clk         (clk),
        .reset       (reset),
        .tick        (timerTick),
        .restart     (startEdge), // see R12
        .reloadValue (baudTimerReload),
        .overflow    (rxOvf)
    );

    // ------------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------------
    reg       txBusy_r;
    reg       txHalf_r;
    reg [3:0] txBit_r;
    reg [9:0] txShift_r;
    reg [3:0] txLen_r;
    reg       txFlagDone_r;
    reg       txWait_r;
    wire      txBitEnd = txBusy_r && txOvf && txHalf_r; // overflow halved, see R12

    // 9-bit mode flags at the start of stop; 8-bit right after the 8th bit
    assign txDoneSet = txBitEnd && !txFlagDone_r &&
                       (txBit_r == txLen_r - 4'd2); // see R8

    always @(posedge clk) begin
        if (reset) begin
            txBusy_r     <= 1'b0;
            txHalf_r     <= 1'b0;
            txBit_r      <= 4'd0;
            txShift_r    <= 10'h3ff;
            txLen_r      <= `FRAME8_BITS;
            txFlagDone_r <= 1'b0;
            txWait_r     <= 1'b0;
            txPin        <= 1'b1; // see R16
        end else if (bufWr && !txBusy_r) begin
            // frame: start, data lsb first, ninth in 9-bit mode only, stop; see R13 R6 R14
            txBusy_r     <= 1'b1;
            txHalf_r     <= 1'b0;
            txBit_r      <= 4'd0;
            txFlagDone_r <= 1'b0;
            txLen_r      <= frameWidthSelect_r ? `FRAME9_BITS : `FRAME8_BITS;
            txShift_r    <= frameWidthSelect_r ? {1'b1, txNinthBit_r, regWdata}
                                               : {1'b1, 1'b1, regWdata};
            txWait_r     <= 1'b1;
        end else if (txBusy_r && txOvf && txWait_r) begin
            // free-running timer: start bit waits for an overflow so it lasts a full bit
            txWait_r <= 1'b0;
            txPin    <= 1'b0; // see R12 R13
        end else if (txBusy_r && txOvf) begin
            txHalf_r <= ~txHalf_r;
            if (txHalf_r) begin
                if (txDoneSet)
                    txFlagDone_r <= 1'b1;
                if (txBit_r == txLen_r - 4'd1) begin
                    txBusy_r <= 1'b0;
                    txPin    <= 1'b1; // see R16
                end else begin
                    txBit_r   <= txBit_r + 4'd1;
                    txPin     <= txShift_r[0];
                    txShift_r <= {1'b1, txShift_r[9:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------------
    // samples at the middle of each bit: first overflow after the edge
    reg       rxHalf_r;
    reg [3:0] rxBit_r;
    reg [9:0] rxShift_r;
    reg [3:0] rxLen_r;
    wire      rxSample = rxActive_r && rxOvf && !rxHalf_r;
    wire      rxStopNow = rxSample && (rxBit_r == rxLen_r - 4'd1);
    wire      rxNine = (rxLen_r == `FRAME9_BITS);

    assign rxByte       = rxNine ? rxShift_r[8:1] : rxShift_r[9:2];
    assign rxNinthValue = rxNine ? rxShift_r[9] : rxPin; // see R7
    // in 9-bit mode the stop bit level does not matter
    wire matchOk = !addressMatchEnable_r ||
                   (rxNine ? rxShift_r[9] : rxPin); // see R3 R4
    assign rxAccept = rxStopNow && !rxDoneFlag_r && matchOk; // see R15

    always @(posedge clk) begin
        if (reset) begin
            rxPrev_r   <= 1'b1;
            rxActive_r <= 1'b0;
            rxHalf_r   <= 1'b0;
            rxBit_r    <= 4'd0;
            rxShift_r  <= 10'h000;
            rxLen_r    <= `FRAME8_BITS;
        end else begin
            rxPrev_r <= rxPin;
            if (startEdge) begin
                rxActive_r <= 1'b1;
                rxHalf_r   <= 1'b0;
                rxBit_r    <= 4'd0;
                rxLen_r    <= frameWidthSelect_r ? `FRAME9_BITS : `FRAME8_BITS;
            end else if (rxActive_r && rxOvf) begin
                rxHalf_r <= ~rxHalf_r;
                if (!rxHalf_r) begin
                    if (rxBit_r == 4'd0 && rxPin)
                        rxActive_r <= 1'b0; // false start, glitch rejected
                    else if (rxStopNow)
                        rxActive_r <= 1'b0;
                    else begin
                        rxBit_r   <= rxBit_r + 4'd1;
                        rxShift_r <= {rxPin, rxShift_r[9:1]};
                    end
                end
            end
        end
    end

endmodule // uart_serial_port_control

`default_nettype wire

/* File: uart_spc_props.sv */
// assertions on the serial port control block ports
// assumes reload 8'hfe with tick always high, so one bit is 4 cycles
`timescale 1ns/1ps
`default_nettype none
module uart_spc_props (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       intEnable,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       txPin,
    input wire logic       irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_low4; !txPin [*4]; endsequence
    sequence s_high4; txPin [*4]; endsequence
    property p_idle; $fell(reset) |-> txPin; endproperty
    property p_lowBit; $fell(txPin) |-> s_low4; endproperty
    property p_highBit; $rose(txPin) |-> s_high4; endproperty
    property p_unused; regRead && regAddr == 8'h98 |=> regRdata[6]; endproperty
    property p_unmapped;
        regRead && regAddr != 8'h98 && regAddr != 8'h99 |=> regRdata == 8'h00;
    endproperty
    property p_hold; !regRead |=> $stable(regRdata); endproperty
    property p_irqGate; !intEnable |-> !irq; endproperty
    // only a control write or clearing intEnable may drop a raised request
    property p_flagsHold;
        irq && !(regWrite && regAddr == 8'h98) |=> irq || !intEnable;
    endproperty
    a_idle: assert property (p_idle) else $error("tx line low after reset");
    a_lowBit: assert property (p_lowBit) else $error("low bit too short");
    a_highBit: assert property (p_highBit) else $error("high bit too short");
    a_unused: assert property (p_unused) else $error("bit 6 read zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data changed");
    a_irqGate: assert property (p_irqGate) else $error("irq while disabled");
    a_flagsHold: assert property (p_flagsHold) else $error("flag cleared");
endmodule // uart_spc_props
bind uart_serial_port_control uart_spc_props chk (.clk(clk), .reset(reset),
    .intEnable(intEnable), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .txPin(txPin), .irq(irq));
`default_nettype wire

/* File: remote_peer.sv */
// far-end serial transceiver model
// assumes a 4-cycle bit time; driven and sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module remote_peer (
    input  wire logic       clk,
    input  wire logic       txLine,
    input  wire logic       nineBit,
    output var  logic       rxLine,
    output var  logic [9:0] capBits,
    output var  logic [7:0] frameCnt
);
    int k;
    initial begin
        rxLine = 1'b1;
        capBits = 10'h000;
        frameCnt = 8'h00;
    end
    // bits holds data lsb first, then ninth bit if any, then stop
    task automatic sendFrame(input logic [9:0] bits, input int n);
        @(negedge clk) rxLine <= 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            rxLine <= bits[i];
            repeat (4) @(negedge clk);
        end
        rxLine <= 1'b1;
    endtask
    // samples near mid-bit, half a bit after the start edge
    always begin
        @(negedge clk);
        if (txLine === 1'b0) begin
            repeat (2) @(negedge clk);
            for (k = 0; k < (nineBit ? 10 : 9); k++) begin
                repeat (4) @(negedge clk);
                capBits[k] <= txLine;
            end
            frameCnt <= frameCnt + 8'h01;
        end
    end
endmodule // remote_peer
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the serial port control block
// assumes remote_peer on the serial pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       intEnable = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic       regWrite = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic       regRead = 1'b0;
    logic       nineBit = 1'b0;
    wire  [7:0] regRdata;
    wire        rxPin;
    wire        txPin;
    wire        irq;
    wire  [9:0] capBits;
    wire  [7:0] frameCnt;
    int         error_cnt = 0;
    int         check_count = 0;
    always #10 clk = ~clk;
    // tick tied high and short reload keep a bit at 4 cycles
    uart_serial_port_control dut (.clk(clk), .reset(reset), .timerTick(1'b1),
        .baudTimerReload(8'hfe), .intEnable(intEnable), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
        .regRdata(regRdata), .rxPin(rxPin), .txPin(txPin), .irq(irq));
    remote_peer peer (.clk(clk), .txLine(txPin), .nineBit(nineBit), .rxLine(rxPin),
        .capBits(capBits), .frameCnt(frameCnt));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic chkReg(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        chk(what, exp, regRdata);
    endtask
    task automatic txByte(input logic [7:0] d, input logic [1:0] tail, input logic [7:0] ctl);
        logic [7:0] n0;
        n0 = frameCnt;
        regWr(8'h99, d);
        for (int i = 0; i < 400 && frameCnt == n0; i++) @(negedge clk);
        chk("tx frames", n0 + 8'h01, frameCnt);
        chk("tx data", d, capBits[7:0]);
        chk("tx tail", {6'h0, tail}, nineBit ? {6'h0, capBits[9:8]} : {7'h0, capBits[8]});
        chkReg("tx ctrl", 8'h98, ctl);
        chk("tx irq", 8'h01, {7'h0, irq});
        regWr(8'h98, 8'h00);
    endtask
    task automatic rxFrame(input logic [7:0] ctl, input logic [9:0] bits, input int n,
                           input logic [7:0] expCtl, input logic [7:0] expBuf);
        regWr(8'h98, ctl);
        peer.sendFrame(bits, n);
        repeat (4) @(negedge clk);
        chkReg("rx ctrl", 8'h98, expCtl);
        chkReg("rx buffer", 8'h99, expBuf);
    endtask
    task automatic t_regs;
        chkReg("reset ctrl", 8'h98, 8'h40);
        regWr(8'h98, 8'h03);
        chk("sw irq", 8'h01, {7'h0, irq});
        @(negedge clk) intEnable = 1'b0;
        @(negedge clk);
        chk("masked irq", 8'h00, {7'h0, irq});
        intEnable = 1'b1;
        regWr(8'h98, 8'h00);
        chk("irq cleared", 8'h00, {7'h0, irq});
        chkReg("ctrl cleared", 8'h98, 8'h40);
        chkReg("unmapped", 8'h55, 8'h00);
    endtask
    task automatic t_tx;
        regWr(8'h98, 8'h08);
        txByte(8'ha5, 2'b01, 8'h4a);
        nineBit = 1'b1;
        regWr(8'h98, 8'h88);
        txByte(8'h3c, 2'b11, 8'hca);
        regWr(8'h98, 8'h80);
        txByte(8'hc3, 2'b10, 8'hc2);
    endtask
    task automatic t_rx;
        rxFrame(8'h10, {2'b01, 8'h96}, 9, 8'h55, 8'h96);
        rxFrame(8'h11, {2'b01, 8'h11}, 9, 8'h51, 8'h96);
        rxFrame(8'h00, {2'b01, 8'h5a}, 9, 8'h40, 8'h96);
        rxFrame(8'h30, {2'b00, 8'h77}, 9, 8'h70, 8'h96);
        rxFrame(8'h10, {2'b00, 8'h77}, 9, 8'h51, 8'h77);
        rxFrame(8'hb0, {2'b10, 8'h21}, 10, 8'hf0, 8'h77);
        rxFrame(8'hb0, {2'b11, 8'h42}, 10, 8'hf5, 8'h42);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        intEnable = 1'b1;
        t_regs();
        t_tx();
        t_rx();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
